// ---- design/flash_cmd_seq.v ----
// serial flash command sequencer: burst-wrap setting, page program, sector erase
`timescale 1ns/1ps
`include "flash_seq_defines.vh"

module flash_cmd_seq #(
    parameter PROG_CYCLES  = `PROG_TIME_US * `CLK_MHZ,
    parameter ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ
) (
    // clock and reset
    input  wire         sys_clk_i,
    input  wire         sys_rst_i,
    input  wire         soft_reset_i,
    // serial link pins
    input  wire         cs_n_i,
    input  wire         sclk_i,
    input  wire [3:0]   quad_line_i,
    // mode and status inputs
    input  wire         four_line_command_mode_i,
    input  wire         four_byte_mode_i,
    input  wire         quad_io_enable_bit_i,
    input  wire         write_enable_set_i,
    input  wire         read_param_load_i,
    input  wire [1:0]   read_param_wrap_i,
    // protection
    input  wire         protect_complement_bit_i,
    input  wire         protect_top_bottom_bit_i,
    input  wire [3:0]   protect_field_i,
    input  wire         lock_hit_i,
    output wire [31:0]  lock_query_addr_o,
    // status
    output wire         busy_o,
    output wire         write_enable_latch_o,
    // wrap configuration
    output wire [7:0]   wrap_config_byte_o,
    output wire         wrap_enable_o,
    output wire [1:0]   wrap_length_field_o,
    output wire [6:0]   wrap_section_bytes_o,
    // array operation
    output wire         prog_start_o,
    output wire         erase_start_o,
    output wire         op_done_o,
    output wire [31:0]  op_addr_o,
    output wire [255:0] byte_valid_o,
    input  wire [7:0]   array_rd_addr_i,
    output wire [7:0]   array_rd_data_o
);
    localparam [3:0] ST_OPC  = 4'h1;
    localparam [3:0] ST_ADDR = 4'h2;
    localparam [3:0] ST_DATA = 4'h4;
    localparam [3:0] ST_SKIP = 4'h8;

    localparam [2:0] K_WRAP  = 3'h1;
    localparam [2:0] K_PROG  = 3'h2;
    localparam [2:0] K_ERASE = 3'h4;
    localparam [31:0] PROG_LAST  = PROG_CYCLES - 1;
    localparam [31:0] ERASE_LAST = ERASE_CYCLES - 1;

    // pin synchronisers
    reg         cs_m_reg;
    reg         cs_s_reg;
    reg         cs_d_reg;
    reg         ck_m_reg;
    reg         ck_s_reg;
    reg         ck_d_reg;
    reg [3:0]   io_m_reg;
    reg [3:0]   io_s_reg;

    // command state
    reg [3:0]   state_reg;
    reg [2:0]   kind_reg;
    reg         quad_reg;
    reg [5:0]   cnt_reg;
    reg [5:0]   addr_len_reg;
    reg [7:0]   sh_reg;
    reg [31:0]  addr_reg;
    reg [7:0]   off_reg;
    reg         got_byte_reg;
    reg         wrap_got_reg;

    // page buffer write port
    reg         pb_we_reg;
    reg [7:0]   pb_waddr_reg;
    reg [7:0]   pb_wdata_reg;
    reg [255:0] valid_reg;

    // status and outputs
    reg         busy_reg;
    reg         wel_reg;
    reg [31:0]  timer_reg;
    reg [7:0]   wrap_cfg_reg;
    reg         prog_start_reg;
    reg         erase_start_reg;
    reg         done_reg;
    reg [31:0]  op_addr_reg;

    // edge detection on the synchronised copies only
    wire cs_rise = cs_s_reg & ~cs_d_reg;
    wire ck_rise = ck_s_reg & ~ck_d_reg & ~cs_s_reg;

    // quad program moves address and data on all four lines
    wire        wide      = four_line_command_mode_i | (quad_reg & (state_reg != ST_OPC));
    wire [7:0]  sh_next   = wide ? {sh_reg[3:0], io_s_reg} : {sh_reg[6:0], io_s_reg[0]};
    wire [31:0] addr_next = wide ? {addr_reg[27:0], io_s_reg} : {addr_reg[30:0], io_s_reg[0]};
    wire [5:0]  cnt_step  = cnt_reg + (wide ? 6'h04 : 6'h01);

    // opcode decode
    wire spi      = ~four_line_command_mode_i;
    wire op_wrap  = (sh_next == `OPC_SET_WRAP) & spi;
    wire op_pp    = (sh_next == `OPC_PAGE_PROG);
    wire op_pp4   = (sh_next == `OPC_PAGE_PROG4) & spi;
    wire op_qpp   = (sh_next == `OPC_QUAD_PROG) & spi;
    wire op_qpp4  = (sh_next == `OPC_QUAD_PROG4) & spi;
    wire op_se    = (sh_next == `OPC_SECTOR_ERASE);
    wire op_quad  = op_qpp | op_qpp4;
    wire op_prog  = op_pp | op_pp4 | op_quad;
    wire op_long  = op_pp4 | op_qpp4 | four_byte_mode_i;
    wire prog_ok  = op_prog & wel_reg & (~op_quad | quad_io_enable_bit_i);
    wire erase_ok = op_se & wel_reg;

    // block protection decode over 64 KB blocks
    reg  [9:0] prot_blocks;
    wire [9:0] blk = {1'b0, addr_reg[`BLOCK_HI:`BLOCK_LO]};
    always @* begin
        if (protect_field_i == 4'h0) begin
            prot_blocks = 10'h000;
        end else if (protect_field_i >= `PROT_FULL_LEVEL) begin
            prot_blocks = `NUM_BLOCKS;
        end else begin
            prot_blocks = 10'h001 << (protect_field_i - 4'h1);
        end
    end
    wire in_range  = protect_top_bottom_bit_i ? (blk < prot_blocks)
                                              : (blk >= (`NUM_BLOCKS - prot_blocks));
    wire prot_hit  = (in_range ^ protect_complement_bit_i) | lock_hit_i;

    // a write on the select edge is aligned only at a byte boundary
    wire aligned   = (state_reg == ST_DATA) & (cnt_reg == 6'h00);
    wire go_prog   = cs_rise & aligned & (kind_reg == K_PROG) & got_byte_reg
                     & ~prot_hit & ~busy_reg;
    wire go_erase  = cs_rise & aligned & (kind_reg == K_ERASE) & ~got_byte_reg
                     & ~prot_hit & ~busy_reg;

    always @(posedge sys_clk_i) begin
        cs_m_reg <= cs_n_i;
        cs_s_reg <= cs_m_reg;
        cs_d_reg <= cs_s_reg;
        ck_m_reg <= sclk_i;
        ck_s_reg <= ck_m_reg;
        ck_d_reg <= ck_s_reg;
        io_m_reg <= quad_line_i;
        io_s_reg <= io_m_reg;
    end

    // serial command engine
    always @(posedge sys_clk_i) begin
        pb_we_reg <= 1'b0;
        if (sys_rst_i) begin
            state_reg    <= ST_OPC;
            kind_reg     <= K_WRAP;
            quad_reg     <= 1'b0;
            cnt_reg      <= 6'h00;
            addr_len_reg <= `ADDR3_BITS;
            sh_reg       <= 8'h00;
            addr_reg     <= 32'h00000000;
            off_reg      <= 8'h00;
            got_byte_reg <= 1'b0;
            wrap_got_reg <= 1'b0;
            pb_waddr_reg <= 8'h00;
            pb_wdata_reg <= 8'h00;
            valid_reg    <= 256'h0;
        end else if (cs_s_reg) begin
            // deselected: every command ends here, partial ones are dropped
            state_reg <= ST_OPC;
            quad_reg  <= 1'b0;
            cnt_reg   <= 6'h00;
        end else if (ck_rise) begin
            case (state_reg)
                ST_OPC: begin
                    sh_reg  <= sh_next;
                    cnt_reg <= cnt_step;
                    if (cnt_step == `BYTE_BITS) begin
                        cnt_reg      <= 6'h00;
                        got_byte_reg <= 1'b0;
                        wrap_got_reg <= 1'b0;
                        addr_reg     <= 32'h00000000; // 3-byte addresses start clean
                        if (busy_reg) begin
                            state_reg <= ST_SKIP;
                        end else if (op_wrap) begin
                            state_reg    <= ST_ADDR;
                            kind_reg     <= K_WRAP;
                            addr_len_reg <= four_byte_mode_i ? `ADDR4_BITS : `ADDR3_BITS;
                        end else if (prog_ok) begin
                            state_reg    <= ST_ADDR;
                            kind_reg     <= K_PROG;
                            quad_reg     <= op_quad;
                            addr_len_reg <= op_long ? `ADDR4_BITS : `ADDR3_BITS;
                            valid_reg    <= 256'h0;
                        end else if (erase_ok) begin
                            state_reg    <= ST_ADDR;
                            kind_reg     <= K_ERASE;
                            addr_len_reg <= four_byte_mode_i ? `ADDR4_BITS : `ADDR3_BITS;
                        end else begin
                            state_reg <= ST_SKIP;
                        end
                    end
                end
                ST_ADDR: begin
                    addr_reg <= addr_next;
                    cnt_reg  <= cnt_step;
                    if (cnt_step == addr_len_reg) begin
                        state_reg <= ST_DATA;
                        cnt_reg   <= 6'h00;
                        off_reg   <= addr_next[`PAGE_BITS-1:0];
                    end
                end
                ST_DATA: begin
                    sh_reg  <= sh_next;
                    cnt_reg <= cnt_step;
                    if (cnt_step == `BYTE_BITS) begin
                        cnt_reg      <= 6'h00;
                        got_byte_reg <= 1'b1;
                        if (kind_reg == K_PROG) begin
                            // offset rolls over inside the page
                            pb_we_reg          <= 1'b1;
                            pb_waddr_reg       <= off_reg;
                            pb_wdata_reg       <= sh_next;
                            valid_reg[off_reg] <= 1'b1;
                            off_reg            <= off_reg + 8'h01;
                        end
                        if (kind_reg == K_WRAP) begin
                            wrap_got_reg <= 1'b1;
                        end
                    end
                end
                ST_SKIP: begin
                    state_reg <= ST_SKIP;
                end
                default: begin
                    state_reg <= ST_SKIP;
                end
            endcase
        end
    end

    // wrap configuration: only the first byte after the dummy bits counts
    wire wrap_take = ck_rise & (state_reg == ST_DATA) & (kind_reg == K_WRAP)
                     & ~wrap_got_reg & (cnt_step == `BYTE_BITS);
    always @(posedge sys_clk_i) begin
        if (sys_rst_i | soft_reset_i) begin
            wrap_cfg_reg <= `WRAP_CFG_RST;
        end else if (wrap_take) begin
            // top bit and low nibble carry no meaning and are stored as zero
            wrap_cfg_reg <= sh_next & 8'h70;
        end else if (read_param_load_i) begin
            wrap_cfg_reg[`WRAP_LEN_HI:`WRAP_LEN_LO] <= read_param_wrap_i;
        end
    end

    // self-timed program / erase cycle
    always @(posedge sys_clk_i) begin
        prog_start_reg  <= 1'b0;
        erase_start_reg <= 1'b0;
        done_reg        <= 1'b0;
        if (sys_rst_i) begin
            busy_reg    <= 1'b0;
            wel_reg     <= 1'b0;
            timer_reg   <= 32'h00000000;
            op_addr_reg <= 32'h00000000;
        end else begin
            if (go_prog) begin
                busy_reg       <= 1'b1;
                timer_reg      <= PROG_LAST;
                prog_start_reg <= 1'b1;
                op_addr_reg    <= {addr_reg[31:`PAGE_BITS], 8'h00};
            end else if (go_erase) begin
                busy_reg        <= 1'b1;
                timer_reg       <= ERASE_LAST;
                erase_start_reg <= 1'b1;
                op_addr_reg     <= {addr_reg[31:`SECTOR_BITS], 12'h000};
            end else if (busy_reg) begin
                if (timer_reg == 32'h00000000) begin
                    busy_reg <= 1'b0;
                    wel_reg  <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    timer_reg <= timer_reg - 32'h00000001;
                end
            end
            // a latch set in the same cycle as the end-of-cycle clear wins
            if (write_enable_set_i) begin
                wel_reg <= 1'b1;
            end
        end
    end

    page_buffer u_page_buffer (
        .clk_i   (sys_clk_i),
        .rst_i   (sys_rst_i),
        .we_i    (pb_we_reg),
        .waddr_i (pb_waddr_reg),
        .wdata_i (pb_wdata_reg),
        .raddr_i (array_rd_addr_i),
        .rdata_o (array_rd_data_o)
    );

    assign lock_query_addr_o    = addr_reg;
    assign busy_o               = busy_reg;
    assign write_enable_latch_o = wel_reg;
    assign wrap_config_byte_o   = wrap_cfg_reg;
    // read logic applies this to every later quad read in standard mode
    assign wrap_enable_o        = ~wrap_cfg_reg[`WRAP_DIS_POS];
    assign wrap_length_field_o  = wrap_cfg_reg[`WRAP_LEN_HI:`WRAP_LEN_LO];
    assign wrap_section_bytes_o = `WRAP_BASE_BYTES << wrap_length_field_o;
    assign prog_start_o         = prog_start_reg;
    assign erase_start_o        = erase_start_reg;
    assign op_done_o            = done_reg;
    assign op_addr_o            = op_addr_reg;
    assign byte_valid_o         = valid_reg;
endmodule // flash_cmd_seq

// ---- design/flash_seq_defines.vh ----
// constants for the program / erase / burst-wrap command sequencer
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH

// opcodes
`define OPC_SET_WRAP      8'h77
`define OPC_PAGE_PROG     8'h02
`define OPC_PAGE_PROG4    8'h12
`define OPC_QUAD_PROG     8'h32
`define OPC_QUAD_PROG4    8'h34
`define OPC_SECTOR_ERASE  8'h20

// wrap configuration byte fields and reset value (wrap disabled, 8-byte length)
`define WRAP_DIS_POS      4
`define WRAP_LEN_HI       6
`define WRAP_LEN_LO       5
`define WRAP_CFG_RST      8'h10
`define WRAP_BASE_BYTES   7'h08

// addressing and geometry
`define ADDR3_BITS        6'h18
`define ADDR4_BITS        6'h20
`define BYTE_BITS         6'h08
`define PAGE_BITS         8
`define SECTOR_BITS       12
`define BLOCK_HI          24
`define BLOCK_LO          16
`define NUM_BLOCKS        10'h200
`define PROT_FULL_LEVEL   4'hA

// self-timed cycles
`define CLK_MHZ           250
`define PROG_TIME_US      1000
`define ERASE_TIME_US     50000

`endif

// ---- design/page_buffer.v ----
// 256-byte program page buffer with registered read port
`timescale 1ns/1ps
module page_buffer (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // write port
    input  wire       we_i,
    input  wire [7:0] waddr_i,
    input  wire [7:0] wdata_i,
    // read port
    input  wire [7:0] raddr_i,
    output reg  [7:0] rdata_o
);
    reg [7:0] mem [0:255];

    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule // page_buffer

// ---- tb/flash_cmd_seq_asserts.sv ----
// checker on status, wrap and operation outputs of the sequencer
`timescale 1ns/1ps
module flash_cmd_seq_asserts #(
    parameter PROG_CYCLES  = 20,
    parameter ERASE_CYCLES = 40
) (
    // clock and reset
    input wire        sys_clk_i,
    input wire        sys_rst_i,
    // watched signals
    input wire        soft_reset_i,
    input wire        write_enable_set_i,
    input wire        busy_o,
    input wire        write_enable_latch_o,
    input wire [7:0]  wrap_config_byte_o,
    input wire        wrap_enable_o,
    input wire [1:0]  wrap_length_field_o,
    input wire [6:0]  wrap_section_bytes_o,
    input wire        prog_start_o,
    input wire        erase_start_o,
    input wire        op_done_o,
    input wire [31:0] op_addr_o
);
    reg [31:0] busy_cnt_reg;
    reg        erase_kind_reg;
    wire       start = prog_start_o | erase_start_o;
    always @(posedge sys_clk_i) begin
        if (sys_rst_i || !busy_o)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
        if (start)
            erase_kind_reg <= erase_start_o;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wrap_rsv_zero_a:
        assert property (wrap_config_byte_o[7] == 1'b0 && wrap_config_byte_o[3:0] == 4'h0)
        else $error("wrap byte reserved bits set");
    wrap_len_map_a:
        assert property (wrap_section_bytes_o == (7'h08 << wrap_length_field_o)
            && wrap_length_field_o == wrap_config_byte_o[6:5]) else $error("wrap length wrong");
    wrap_enable_map_a:
        assert property (wrap_enable_o == !wrap_config_byte_o[4]) else $error("wrap enable wrong");
    soft_reset_wrap_a:
        assert property ($rose(soft_reset_i) |=> wrap_config_byte_o == 8'h10)
        else $error("wrap byte not reset");
    start_needs_latch_a:
        assert property (start |-> write_enable_latch_o) else $error("start without latch");
    busy_no_start_a:
        assert property (busy_o && $past(busy_o) |-> !start) else $error("start while busy");
    start_busy_hold_a:
        assert property (start |-> busy_o ##1 busy_o [*8]) else $error("busy not held");
    end_clears_latch_a:
        assert property ($fell(busy_o) |-> op_done_o
            && (!write_enable_latch_o || $past(write_enable_set_i))) else $error("latch kept");
    busy_length_a:
        assert property ($fell(busy_o) |-> busy_cnt_reg == (erase_kind_reg ? ERASE_CYCLES
            : PROG_CYCLES)) else $error("busy length wrong");
    op_addr_align_a:
        assert property (start |-> op_addr_o[7:0] == 8'h00
            && (!erase_start_o || op_addr_o[11:8] == 4'h0)) else $error("op address unaligned");
    cover property (prog_start_o);
    cover property (erase_start_o);
    cover property ($fell(wrap_config_byte_o[4]));
endmodule // flash_cmd_seq_asserts
bind flash_cmd_seq flash_cmd_seq_asserts #(.PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) chk_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .soft_reset_i(soft_reset_i), .write_enable_set_i(write_enable_set_i), .busy_o(busy_o),
    .write_enable_latch_o(write_enable_latch_o), .wrap_config_byte_o(wrap_config_byte_o),
    .wrap_enable_o(wrap_enable_o), .wrap_length_field_o(wrap_length_field_o),
    .wrap_section_bytes_o(wrap_section_bytes_o), .prog_start_o(prog_start_o),
    .erase_start_o(erase_start_o), .op_done_o(op_done_o), .op_addr_o(op_addr_o));

// ---- tb/flash_host_model.sv ----
// behavioural host controller driving select, serial clock and io lines
`timescale 1ns/1ps
module flash_host_model (
    // link pins
    output reg       cs_n_o,
    output reg       sclk_o,
    output reg [3:0] quad_line_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        quad_line_o = 4'hA;
    end
    // data changes while the clock is low; clock idles low between frames
    task shift(input [31:0] v, input integer n, input integer w);
        integer i;
        begin
            for (i = n; i > 0; i = i - w) begin
                quad_line_o = (w == 4) ? v[i-1 -: 4] : {~quad_line_o[3:1], v[i-1]};
                #40 sclk_o = 1'b1;
                #40 sclk_o = 1'b0;
            end
        end
    endtask
    task frame(input [7:0] op, input [31:0] a, input integer ab, nb, input [7:0] d0,
               input integer ow, dw, cut);
        integer k;
        begin
            #13 cs_n_o = 1'b0;
            #40 shift(op, 8, ow);
            shift(a, ab, dw);
            for (k = 0; k < nb; k = k + 1)
                shift(d0 + k[7:0] + (k[8] ? 8'h5A : 8'h00), 8, dw);
            shift(32'h0, cut, dw);
            #40 cs_n_o = 1'b1;
            // released lines must not keep showing the last bit
            quad_line_o = ~quad_line_o;
            #100;
        end
    endtask
endmodule // flash_host_model

// ---- tb/test_serial_flash_wrap_program_erase.sv ----
// self-checking bench for the sequencer against a behavioural page model
`timescale 1ns/1ps
module test_serial_flash_wrap_program_erase;
    reg          clk = 1'b0, rst = 1'b1, srst = 1'b0, fcm = 1'b0, fbm = 1'b0, qe = 1'b0;
    reg          wes = 1'b0, rpl = 1'b0, lock = 1'b0, tbb = 1'b0, cmpb = 1'b0;
    reg  [1:0]   rpw = 2'h0;
    reg  [3:0]   prot = 4'h0;
    reg  [7:0]   rda = 8'h00, b, d0, sv;
    reg  [31:0]  ra;
    reg  [255:0] ev = 256'h0;
    reg  [7:0]   mem [0:255];
    integer      num_errors = 0, tests_run = 0, starts = 0, erases = 0, seed = 74593, i;
    wire         cs_n, sclk, busy, write_enable_latch, wen, ps, es, done;
    wire [3:0]   qd;
    wire [1:0]   wlen;
    wire [6:0]   wsec;
    wire [7:0]   wcfg, rdd;
    wire [31:0]  oaddr, lqa;
    wire [255:0] bv;
    initial begin
        forever #2 clk = ~clk;
    end
    flash_host_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .quad_line_o(qd));
    flash_cmd_seq #(.PROG_CYCLES(200), .ERASE_CYCLES(3000)) dut_u (
        .sys_clk_i(clk), .sys_rst_i(rst), .soft_reset_i(srst), .cs_n_i(cs_n), .sclk_i(sclk),
        .quad_line_i(qd), .four_line_command_mode_i(fcm), .four_byte_mode_i(fbm),
        .quad_io_enable_bit_i(qe), .write_enable_set_i(wes), .read_param_load_i(rpl),
        .read_param_wrap_i(rpw), .protect_complement_bit_i(cmpb),
        .protect_top_bottom_bit_i(tbb), .protect_field_i(prot), .lock_hit_i(lock),
        .lock_query_addr_o(lqa), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
        .wrap_config_byte_o(wcfg), .wrap_enable_o(wen), .wrap_length_field_o(wlen),
        .wrap_section_bytes_o(wsec), .prog_start_o(ps), .erase_start_o(es), .op_done_o(done),
        .op_addr_o(oaddr), .byte_valid_o(bv), .array_rd_addr_i(rda), .array_rd_data_o(rdd));
    always @(posedge clk) begin
        if (ps || es)
            starts <= starts + 1;
        if (es)
            erases <= erases + 1;
    end
    task chk(input [255:0] got, input [255:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d errors %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task wait_idle;
        integer k;
        begin
            k = 0;
            while (busy !== 1'b0 && k < 5000) begin
                @(posedge clk);
                k = k + 1;
            end
            if (busy !== 1'b0) begin
                num_errors = num_errors + 1;
                end_sim;
            end
            @(negedge clk);
        end
    endtask
    task latch_set;
        begin
            @(negedge clk) wes = 1'b1;
            @(negedge clk) wes = 1'b0;
        end
    endtask
    // ex: 0 refused, 1 started and run to the end, 2 started and left busy
    task run(input [7:0] op, input [31:0] a, input integer ab, nb, ow, dw, cut, ex);
        integer k, n0, e0;
        begin
            d0 = $random(seed);
            n0 = starts;
            e0 = erases;
            host_u.frame(op, a, ab, nb, d0, ow, dw, cut);
            repeat (8) @(negedge clk);
            chk(starts - n0, ex != 0);
            chk(erases - e0, ex != 0 && nb == 0);
            if (ex != 0) begin
                chk(oaddr, a & (nb != 0 ? ~32'hFF : ~32'hFFF));
                chk(lqa, a);
                chk(busy, 1);
            end
            if (ex != 0 && nb != 0) begin
                ev = 256'h0;
                for (k = 0; k < nb; k = k + 1) begin
                    mem[a[7:0] + k[7:0]] = d0 + k[7:0] + (k[8] ? 8'h5A : 8'h00);
                    ev[a[7:0] + k[7:0]] = 1'b1;
                end
            end
            if (ex == 1) begin
                wait_idle;
                chk(write_enable_latch, 0);
            end
        end
    endtask
    task chk_page;
        integer k;
        begin
            chk(bv, ev);
            for (k = 0; k < 256; k = k + 1) begin
                @(negedge clk) rda = k[7:0];
                @(negedge clk);
                if (ev[k])
                    chk(rdd, mem[k]);
            end
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(busy, 0);
        chk(write_enable_latch, 0);
        chk(wcfg, 8'h10);
        for (i = 0; i < 4; i = i + 1) begin
            @(negedge clk) fbm = i[0];
            b = $random(seed);
            b[6:5] = i[1:0];
            b[4] = 1'b0;
            host_u.frame(8'h77, $random(seed), fbm ? 32 : 24, 1, b, 1, 1, 0);
            chk(wcfg, b & 8'h70);
            chk(wen, 1);
            chk(wsec, 8 << i);
        end
        @(negedge clk) rpw = 2'h1;
        rpl = 1'b1;
        fbm = 1'b0;
        @(negedge clk) rpl = 1'b0;
        chk(wlen, 1);
        @(negedge clk) srst = 1'b1;
        @(negedge clk) srst = 1'b0;
        chk(wcfg, 8'h10);
        host_u.frame(8'h77, 0, 24, 1, 8'h50, 1, 1, 0);
        chk(wcfg, 8'h50);
        chk(wen, 0);
        run(8'h02, 32'h0012_3400, 24, 4, 1, 1, 0, 0);
        latch_set;
        run(8'h02, 32'h00AB_CDF0, 24, 20, 1, 1, 0, 1);
        chk_page;
        latch_set;
        qe = 1'b1;
        ra = $random(seed) & 32'h00FF_FFFF;
        run(8'h34, ra, 32, 258, 1, 4, 0, 1);
        chk_page;
        latch_set;
        qe = 1'b0;
        run(8'h32, ra, 24, 2, 1, 4, 0, 0);
        run(8'h02, ra, 24, 2, 1, 1, 3, 0);
        run(8'h20, ra, 24, 0, 1, 1, 8, 0);
        prot = 4'hA;
        run(8'h02, ra, 24, 1, 1, 1, 0, 0);
        prot = 4'h1;
        tbb = 1'b1;
        run(8'h02, 32'h0000_F000, 24, 1, 1, 1, 0, 0);
        tbb = 1'b0;
        cmpb = 1'b1;
        run(8'h20, ra, 24, 0, 1, 1, 0, 0);
        cmpb = 1'b0;
        prot = 4'h0;
        lock = 1'b1;
        run(8'h20, ra, 24, 0, 1, 1, 0, 0);
        lock = 1'b0;
        fbm = 1'b1;
        run(8'h20, ra, 32, 0, 1, 1, 0, 2);
        sv = wcfg;
        run(8'h77, ra, 32, 1, 1, 1, 0, 0);
        chk(wcfg, sv);
        run(8'h02, ra, 32, 1, 1, 1, 0, 0);
        wait_idle;
        chk(write_enable_latch, 0);
        latch_set;
        fbm = 1'b0;
        run(8'h12, ra, 32, 2, 1, 1, 0, 1);
        chk_page;
        latch_set;
        fcm = 1'b1;
        run(8'h02, ra, 24, 3, 4, 4, 0, 1);
        chk_page;
        end_sim;
    end
endmodule // test_serial_flash_wrap_program_erase
